// *** hdl/pssj_defines.vh ***
// Constants for the preset speed and jog selector
`ifndef PSSJ_DEFINES_VH
`define PSSJ_DEFINES_VH
`define PSSJ_FREQ_W        16
`define PSSJ_NOT_SELECTED  16'h270F
`define PSSJ_FREQ_MAX      16'h0FA0
`define PSSJ_JOG_FREQ_RST  16'h0032
`define PSSJ_JOG_RAMP_RST  16'h0005
`define PSSJ_REF_FREQ_RST  16'h0258
`define PSSJ_HIGH_RST      16'h01F4
`define PSSJ_MID_RST       16'h012C
`define PSSJ_LOW_RST       16'h0064
`define PSSJ_FN_LOW        4'h0
`define PSSJ_FN_MID        4'h1
`define PSSJ_FN_HIGH       4'h2
`define PSSJ_FN_EXT        4'h8
`define PSSJ_MODE_EXT      4'h3
`define PSSJ_MODE_COMB     4'h4
`define PSSJ_RAMP_MAX_C    16'h8CA0
`define PSSJ_RAMP_MAX_F    16'h8CA0
`define PSSJ_SRC_NONE      3'h0
`define PSSJ_SRC_JOG       3'h1
`define PSSJ_SRC_PRESET    3'h2
`define PSSJ_SRC_AIN4      3'h3
`define PSSJ_SRC_AIN2      3'h4
`endif

// *** hdl/pssj_selector.v ***
// Preset speed, jog and analog frequency command selector
`timescale 1ns/10ps
`include "pssj_defines.vh"

// Operation
// (R1) High, middle or low select alone runs presets 1, 2 or 3.
// (R2) Several single selects together: the lowest-ranked active one wins.
// (R3) Select combinations with extension decode speeds 4 to 15.
// (R4) After reset speeds 4 to 15 hold not-selected.
// (R5) Speed 8 not selected and extension alone: run the low preset.
// (R6) Terminal function code 8 makes the extension select.
// (R7) Codes 0, 1, 2 route a terminal to low, middle, high select.
// (R8) Priority: jog, preset, analog terminal 4, analog terminal 2.
// (R9) Presets act only in external or combined mode (3 or 4).
// (R10) Remote function select nonzero disables preset selection.
// (R11) Jog frequency defaults to 5 Hz, range 0 to 400 Hz.
// (R12) Jog ramp defaults to 0.5 s, referenced to 60 Hz.
// (R13) Increment 0: up to 3600 s by 0.1 s; 1: 360 s by 0.01 s.
// (R14) One jog ramp time serves acceleration and deceleration.
// (R15) External jog starts and stops on forward or reverse start.
// (R16) Panel jog runs only while the panel start key is held.
// (R17) S-pattern A: jog ramp referenced to base frequency.
// (R18) Operator should set jog frequency at or above starting frequency.
// (R19) During jog the second ramp select is ignored.
// (R20) Mode 4: panel keys run jog; mode 3: panel jog disabled.
// (R21) Compensation 1 adds analog input to preset frequency.
// (R22) A speed 4 to 15 preset of 9999 is not selected.
// (R23) Without jog or preset, pass the analog command through.
module pssj_selector #(
  parameter NTERM = 12,
  parameter FW    = 16
) (
  input  wire              clk_i,
  input  wire              reset_i,
  input  wire [NTERM-1:0]  terminal_i,
  input  wire [4*NTERM-1:0] terminal_function_assign_i,
  input  wire              jog_select_i,
  input  wire              forward_start_i,
  input  wire              reverse_start_i,
  input  wire              second_ramp_select_i,
  input  wire              panel_jog_mode_i,
  input  wire              panel_forward_key_i,
  input  wire              panel_reverse_key_i,
  input  wire [3:0]        operation_mode_select_i,
  input  wire [3:0]        remote_function_select_i,
  input  wire              compensation_select_i,
  input  wire [1:0]        ramp_pattern_select_i,
  input  wire              time_increment_select_i,
  input  wire              preset_write_i,
  input  wire [3:0]        preset_index_i,
  input  wire [FW-1:0]     preset_data_i,
  input  wire              jog_freq_write_i,
  input  wire              jog_ramp_write_i,
  input  wire [FW-1:0]     param_data_i,
  input  wire [FW-1:0]     base_frequency_i,
  input  wire [FW-1:0]     ramp_reference_frequency_i,
  input  wire              ain4_valid_i,
  input  wire [FW-1:0]     ain4_freq_i,
  input  wire              ain2_valid_i,
  input  wire [FW-1:0]     ain2_freq_i,
  input  wire [FW-1:0]     compensation_i,
  output reg  [FW-1:0]     freq_command_o,
  output reg  [2:0]        freq_source_o,
  output reg               run_o,
  output reg               reverse_o,
  output reg  [FW-1:0]     ramp_time_o,
  output reg  [FW-1:0]     ramp_ref_freq_o,
  output reg               ramp_fine_o,
  output reg               second_ramp_o,
  output reg  [3:0]        speed_index_o
);

// ----------------------------------------------------------------
// Pin synchronisers
// ----------------------------------------------------------------
  localparam NS = NTERM + 6;
  wire [NS-1:0] raw = {terminal_i, jog_select_i, forward_start_i,
                       reverse_start_i, panel_forward_key_i,
                       panel_reverse_key_i, second_ramp_select_i};
  reg  [NS-1:0] sync_a;
  reg  [NS-1:0] sync_b;
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync_a <= {NS{1'b0}};
      sync_b <= {NS{1'b0}};
    end else begin
      sync_a <= raw;
      sync_b <= sync_a;
    end
  end
  wire [NTERM-1:0] term_s = sync_b[NS-1:6];
  wire jog_s = sync_b[5];
  wire fwd_s = sync_b[4];
  wire rev_s = sync_b[3];
  wire pfwd_s = sync_b[2];
  wire prev_s = sync_b[1];
  wire rt_s = sync_b[0];

// ----------------------------------------------------------------
// Terminal routing
// ----------------------------------------------------------------
  function route;
    input [NTERM-1:0]   t;
    input [4*NTERM-1:0] fa;
    input [3:0]         code;
    integer k;
    begin
      route = 1'b0;
      for (k = 0; k < NTERM; k = k + 1) begin
        if (t[k] && fa[4*k +: 4] == code)
          route = 1'b1;
      end
    end
  endfunction

  wire low_speed_select = route(term_s, terminal_function_assign_i,
                                `PSSJ_FN_LOW); // R7
  wire mid_speed_select = route(term_s, terminal_function_assign_i,
                                `PSSJ_FN_MID); // R7
  wire high_speed_select = route(term_s, terminal_function_assign_i,
                                 `PSSJ_FN_HIGH); // R7
  wire extended_speed_select = route(term_s, terminal_function_assign_i,
                                     `PSSJ_FN_EXT); // R6

// ----------------------------------------------------------------
// Preset storage
// ----------------------------------------------------------------
  // Out-of-range writes are dropped so the old value stays
  function fits;
    input [FW-1:0] value;
    input [FW-1:0] limit;
    begin
      fits = value <= limit;
    end
  endfunction

  // Index 1..3 are high, mid, low; 4..15 the extended speeds
  reg [FW-1:0] preset [1:15];
  integer i;
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      preset[1] <= `PSSJ_HIGH_RST;
      preset[2] <= `PSSJ_MID_RST;
      preset[3] <= `PSSJ_LOW_RST;
      for (i = 4; i < 16; i = i + 1)
        preset[i] <= `PSSJ_NOT_SELECTED; // R4
    end else begin
      if (preset_write_i && preset_index_i != 4'h0 &&
          (fits(preset_data_i, `PSSJ_FREQ_MAX) ||
           (preset_index_i >= 4'h4 &&
            preset_data_i == `PSSJ_NOT_SELECTED)))
        preset[preset_index_i] <= preset_data_i; // R22
    end
  end

// ----------------------------------------------------------------
// Jog parameters
// ----------------------------------------------------------------
  reg [FW-1:0] jog_frequency;
  reg [FW-1:0] jog_ramp_time;
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      jog_frequency <= `PSSJ_JOG_FREQ_RST; // R11
      jog_ramp_time <= `PSSJ_JOG_RAMP_RST; // R12
    end else begin
      if (jog_freq_write_i && fits(param_data_i, `PSSJ_FREQ_MAX))
        jog_frequency <= param_data_i; // R11
      // Both increments top out at the same count, so one limit serves
      if (jog_ramp_write_i && fits(param_data_i, `PSSJ_RAMP_MAX_C))
        jog_ramp_time <= param_data_i; // R13
    end
  end

// ----------------------------------------------------------------
// Speed decode
// ----------------------------------------------------------------
  reg [3:0] next_speed;
  reg       next_preset_valid;
  reg [FW-1:0] next_preset_freq;
  always @* begin
    next_speed = 4'h0;
    next_preset_valid = 1'b0;
    next_preset_freq = {FW{1'b0}};
    if (!extended_speed_select) begin
      if (low_speed_select && !mid_speed_select && !high_speed_select)
        next_speed = 4'h3; // R1
      else if (mid_speed_select && !low_speed_select &&
               !high_speed_select)
        next_speed = 4'h2; // R1
      else if (high_speed_select && !low_speed_select &&
               !mid_speed_select)
        next_speed = 4'h1; // R1
      // Pairs give 4 to 6 and all three give 7, so none collide
      else if (low_speed_select || mid_speed_select)
        next_speed = {2'b01, high_speed_select && mid_speed_select,
                      high_speed_select && low_speed_select}; // R3
    end else begin
      next_speed = {1'b1, low_speed_select, mid_speed_select,
                    high_speed_select}; // R3
    end
    if (next_speed >= 4'h1 && next_speed <= 4'h3) begin
      next_preset_valid = 1'b1;
      next_preset_freq = preset[next_speed];
    end else if (next_speed >= 4'h4) begin
      if (preset[next_speed] != `PSSJ_NOT_SELECTED) begin // R22
        next_preset_valid = 1'b1;
        next_preset_freq = preset[next_speed];
      end else if (next_speed == 4'h8) begin
        next_preset_valid = 1'b1; // R5
        next_preset_freq = preset[3];
      end else if (next_speed <= 4'h7) begin
        // Two or three singles fall back to the lowest active one
        next_preset_valid = 1'b1; // R2
        next_preset_freq = low_speed_select ? preset[3] : preset[2];
      end
    end
  end

// ----------------------------------------------------------------
// Command arbitration
// ----------------------------------------------------------------
  wire ext_mode = operation_mode_select_i == `PSSJ_MODE_EXT ||
                  operation_mode_select_i == `PSSJ_MODE_COMB;
  wire preset_on = ext_mode && remote_function_select_i == 4'h0 &&
                   next_preset_valid; // R9 R10
  wire ext_jog = jog_s && (fwd_s || rev_s); // R15
  wire panel_jog = panel_jog_mode_i &&
                   operation_mode_select_i == `PSSJ_MODE_COMB &&
                   (pfwd_s || prev_s); // R16 R20
  wire jog_on = ext_jog || panel_jog;
  wire [FW:0] comp_sum = {1'b0, next_preset_freq} +
                         {1'b0, compensation_i}; // R21
  wire [FW-1:0] comp_freq = comp_sum[FW] ? {FW{1'b1}} : comp_sum[FW-1:0];
  wire ext_run = fwd_s || rev_s; // R15
  wire ext_reverse = rev_s && !fwd_s;

  reg [FW-1:0] next_freq;
  reg [2:0]    next_source;
  reg          next_run;
  reg          next_reverse;
  reg [3:0]    next_index;
  always @* begin
    next_freq = {FW{1'b0}};
    next_source = `PSSJ_SRC_NONE;
    next_run = 1'b0;
    next_reverse = 1'b0;
    next_index = 4'h0;
    // Jog overrides everything below it
    if (jog_on) begin // R8
      next_freq = jog_frequency; // R11
      next_source = `PSSJ_SRC_JOG;
      next_run = 1'b1;
      next_reverse = ext_jog ? ext_reverse : (prev_s && !pfwd_s);
    end else if (preset_on) begin // R8
      next_freq = compensation_select_i ? comp_freq
                                        : next_preset_freq; // R21
      next_source = `PSSJ_SRC_PRESET;
      next_run = ext_run;
      next_reverse = ext_reverse;
      next_index = next_speed;
    end else if (ain4_valid_i) begin // R23
      next_freq = ain4_freq_i;
      next_source = `PSSJ_SRC_AIN4;
      next_run = ext_run;
      next_reverse = ext_reverse;
    end else if (ain2_valid_i) begin // R23
      next_freq = ain2_freq_i;
      next_source = `PSSJ_SRC_AIN2;
      next_run = ext_run;
      next_reverse = ext_reverse;
    end
  end

// ----------------------------------------------------------------
// Command registers
// ----------------------------------------------------------------
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      freq_command_o <= {FW{1'b0}};
      freq_source_o <= `PSSJ_SRC_NONE;
      run_o <= 1'b0;
      reverse_o <= 1'b0;
      speed_index_o <= 4'h0;
    end else begin
      freq_command_o <= next_freq;
      freq_source_o <= next_source;
      run_o <= next_run;
      reverse_o <= next_reverse;
      speed_index_o <= next_index;
    end
  end

// ----------------------------------------------------------------
// Ramp settings
// ----------------------------------------------------------------
  // Masked during jog so a jog always keeps its own ramp time
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ramp_time_o <= `PSSJ_JOG_RAMP_RST;
      ramp_ref_freq_o <= `PSSJ_REF_FREQ_RST;
      ramp_fine_o <= 1'b0;
      second_ramp_o <= 1'b0;
    end else begin
      // One ramp value for both directions; base frequency for S-A
      ramp_time_o <= jog_ramp_time; // R14
      ramp_fine_o <= time_increment_select_i; // R13
      ramp_ref_freq_o <= (ramp_pattern_select_i == 2'h1) ?
                         base_frequency_i :
                         ramp_reference_frequency_i; // R12 R17
      second_ramp_o <= rt_s && !jog_on; // R19
    end
  end
endmodule

// *** sim/pssj_contacts.sv ***
// Contact wiring model: speed selects onto terminals
`timescale 1ns/10ps
`include "pssj_defines.vh"
module pssj_contacts (
  input  wire logic [3:0]  sel_i,
  input  wire logic [11:0] noise_i,
  output logic      [11:0] terminal_o,
  output logic      [47:0] assign_o
);
  // Unassigned terminals chatter; the selector must ignore them
  always_comb begin
    terminal_o = noise_i;
    assign_o = {12{4'hF}};
    assign_o[28+:4] = `PSSJ_FN_LOW;
    assign_o[8+:4] = `PSSJ_FN_MID;
    assign_o[36+:4] = `PSSJ_FN_HIGH;
    assign_o[16+:4] = `PSSJ_FN_EXT;
    terminal_o[7] = sel_i[0];
    terminal_o[2] = sel_i[1];
    terminal_o[9] = sel_i[2];
    terminal_o[4] = sel_i[3];
  end
endmodule

// *** sim/pssj_props.sv ***
// Port checks of the selector
`timescale 1ns/10ps
`include "pssj_defines.vh"
module pssj_props #(
  parameter NTERM = 12,
  parameter FW    = 16
) (
  input wire logic          clk_i,
  input wire logic          reset_i,
  input wire logic          jog_select_i,
  input wire logic          forward_start_i,
  input wire logic          reverse_start_i,
  input wire logic          panel_jog_mode_i,
  input wire logic          panel_forward_key_i,
  input wire logic [3:0]    operation_mode_select_i,
  input wire logic [3:0]    remote_function_select_i,
  input wire logic          time_increment_select_i,
  input wire logic          ain4_valid_i,
  input wire logic [FW-1:0] ain4_freq_i,
  input wire logic [FW-1:0] ain2_freq_i,
  input wire logic [FW-1:0] freq_command_o,
  input wire logic [2:0]    freq_source_o,
  input wire logic          run_o,
  input wire logic          ramp_fine_o,
  input wire logic          second_ramp_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire md3  = operation_mode_select_i == `PSSJ_MODE_EXT;
  wire md4  = operation_mode_select_i == `PSSJ_MODE_COMB;
  wire pre  = freq_source_o == `PSSJ_SRC_PRESET;
  wire idle = !jog_select_i && !forward_start_i && !reverse_start_i;
  // Pins cross two sync stages, so four held cycles are needed
  sequence s_jog; (jog_select_i && forward_start_i && (md3 || md4))[*4];
  endsequence
  sequence s_pkey;
    (panel_jog_mode_i && md4 && panel_forward_key_i && idle)[*4];
  endsequence
  sequence s_p3; (panel_jog_mode_i && md3 && idle)[*4]; endsequence
  a_jog_wins: assert property (s_jog |->
    freq_source_o == `PSSJ_SRC_JOG && run_o) else $error("jog not taken");
  a_jog_no_second: assert property (
    freq_source_o == `PSSJ_SRC_JOG |-> !second_ramp_o)
    else $error("second ramp in jog");
  a_mode_gate: assert property (pre |-> $past(md3 || md4))
    else $error("preset outside modes 3 and 4");
  a_remote_gate: assert property (
    pre |-> $past(remote_function_select_i) == 4'h0)
    else $error("preset with remote set");
  a_panel_hold: assert property (s_pkey |-> run_o)
    else $error("panel jog not running");
  a_panel_off: assert property (s_p3 |-> !run_o)
    else $error("panel jog ran in mode 3");
  a_fine_follow: assert property (!$past(reset_i) |->
    ramp_fine_o == $past(time_increment_select_i))
    else $error("fine ramp flag wrong");
  a_ain4_pass: assert property (freq_source_o == `PSSJ_SRC_AIN4 |->
    freq_command_o == $past(ain4_freq_i)) else $error("ain4 not passed");
  a_ain2_pass: assert property (freq_source_o == `PSSJ_SRC_AIN2 |->
    !$past(ain4_valid_i) && freq_command_o == $past(ain2_freq_i))
    else $error("ain2 not passed");
endmodule
bind pssj_selector pssj_props #(.NTERM(NTERM), .FW(FW)) u_props (.*);

// *** sim/pssj_selector_bench.sv ***
// Self-checking bench of the selector
`timescale 1ns/10ps
module pssj_selector_bench;
  logic        clk_i, reset_i, jog_select_i, forward_start_i, reverse_start_i;
  logic        second_ramp_select_i, panel_jog_mode_i, panel_forward_key_i;
  logic        panel_reverse_key_i, compensation_select_i, ain4_valid_i;
  logic        time_increment_select_i, preset_write_i, jog_freq_write_i;
  logic        jog_ramp_write_i, ain2_valid_i, run_o, reverse_o;
  logic        ramp_fine_o, second_ramp_o;
  logic [1:0]  ramp_pattern_select_i;
  logic [2:0]  freq_source_o;
  logic [3:0]  operation_mode_select_i, remote_function_select_i;
  logic [3:0]  preset_index_i, speed_index_o, sel;
  logic [11:0] terminal_i, noise;
  logic [47:0] terminal_function_assign_i;
  logic [15:0] preset_data_i, param_data_i, base_frequency_i, ain4_freq_i;
  logic [15:0] ramp_reference_frequency_i, ain2_freq_i, compensation_i;
  logic [15:0] freq_command_o, ramp_time_o, ramp_ref_freq_o;
  int          n_fail, checks, s, f, x;
  int          p [1:15];
  pssj_selector uut (.*);
  pssj_contacts ptn (.sel_i(sel), .noise_i(noise), .terminal_o(terminal_i),
                     .assign_o(terminal_function_assign_i));
  initial begin
    clk_i = 0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic chk(string nm, logic [15:0] seen, int exp);
    checks++;
    if (seen !== exp[15:0]) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask
  // Pins take three edges to reach the outputs
  task automatic wt;
    repeat (4) @(negedge clk_i);
  endtask
  task automatic wr(int k, int d);
    preset_data_i = d[15:0];
    param_data_i = d[15:0];
    preset_write_i = k == 0;
    jog_freq_write_i = k == 1;
    jog_ramp_write_i = k == 2;
    @(negedge clk_i);
    {preset_write_i, jog_freq_write_i, jog_ramp_write_i} = 3'h0;
    wt;
  endtask
  function automatic void model(output int src, output int fq,
                                output int sp);
    logic lo, md, hi, ex;
    {ex, hi, md, lo} = sel;
    src = 0;
    fq = 0;
    // Speed code: extension adds 8, pairs and all three give 4 to 7
    sp = ex ? 8 + 4 * lo + 2 * md + hi :
         lo + md + hi > 1 ? 4 + 2 * (hi & md) + (hi & lo) :
         lo ? 3 : md ? 2 : hi;
    if (sp >= 4 && p[sp] == 9999)
      fq = sp == 8 ? p[3] : sp < 8 ? (lo ? p[3] : p[2]) : -1;
    else if (sp > 0)
      fq = p[sp];
    if (sp > 0 && fq >= 0 && operation_mode_select_i inside {3, 4} &&
        remote_function_select_i == 0) begin
      src = 2;
      if (compensation_select_i) fq = fq + compensation_i;
      if (fq > 65535) fq = 65535;
    end else if (ain4_valid_i) begin
      src = 3;
      fq = ain4_freq_i;
    end else if (ain2_valid_i) begin
      src = 4;
      fq = ain2_freq_i;
    end else
      fq = 0;
  endfunction
  task automatic cmp;
    model(s, f, x);
    chk("freq_source", freq_source_o, s);
    chk("freq_command", freq_command_o, f);
    chk("speed_index", speed_index_o, s == 2 ? x : 0);
  endtask
  task automatic report_and_stop;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #400000;
    n_fail++;
    report_and_stop;
  end
  initial begin
    {jog_select_i, forward_start_i, reverse_start_i, second_ramp_select_i,
     panel_jog_mode_i, panel_forward_key_i, panel_reverse_key_i,
     compensation_select_i, ain4_valid_i, ain2_valid_i, preset_write_i,
     time_increment_select_i, jog_freq_write_i, jog_ramp_write_i} = 14'h0;
    {ramp_pattern_select_i, remote_function_select_i, ain4_freq_i} = 22'h0;
    {ain2_freq_i, compensation_i, param_data_i, preset_data_i} = 64'h0;
    {sel, noise, n_fail, checks} = 80'h0;
    p[1] = 500;
    p[2] = 300;
    p[3] = 100;
    for (int k = 4; k < 16; k++) p[k] = 9999;
    {reset_i, operation_mode_select_i, preset_index_i} = 9'h138;
    base_frequency_i = 16'h01F4;
    ramp_reference_frequency_i = 16'h0258;
    void'($urandom(32'h66AD0110));
    repeat (16) @(negedge clk_i);
    chk("ramp_time", ramp_time_o, 5);
    chk("ramp_ref", ramp_ref_freq_o, 600);
    reset_i = 0;
    $display("test reset done");
    {forward_start_i, sel} = 5'h11;
    wt;
    cmp;
    chk("speed_index", speed_index_o, 3);
    sel = 4'h8;
    wt;
    cmp;
    for (int v = 0; v < 3; v++) begin
      wr(0, v == 0 ? 1234 : v == 1 ? 4001 : 9999);
      if (v != 1) p[8] = v == 0 ? 1234 : 9999;
      cmp;
    end
    {preset_index_i, sel} = 8'h43;
    wr(0, 2222);
    p[4] = 2222;
    cmp;
    sel = 4'h7;
    wt;
    cmp;
    $display("test extension done");
    for (int i = 0; i < 60; i++) begin
      sel = 4'($urandom);
      noise = 12'($urandom);
      operation_mode_select_i = 4'($urandom % 6);
      remote_function_select_i = $urandom % 3 ? 4'h0 : 4'($urandom % 14);
      {compensation_select_i, ain4_valid_i, ain2_valid_i} = 3'($urandom);
      compensation_i = 16'($urandom);
      ain4_freq_i = 16'($urandom % 4001);
      ain2_freq_i = 16'($urandom % 4001);
      wt;
      cmp;
      chk("run", run_o, s != 0);
    end
    $display("test random done");
    {sel, operation_mode_select_i, remote_function_select_i} = 12'h130;
    {jog_select_i, second_ramp_select_i, time_increment_select_i} = 3'h7;
    compensation_select_i = 0;
    wr(1, 4001);
    chk("jog_freq", freq_command_o, 50);
    chk("jog_source", freq_source_o, 1);
    chk("second_ramp", second_ramp_o, 0);
    chk("jog_ramp", ramp_time_o, 5);
    chk("ramp_fine", ramp_fine_o, 1);
    chk("ramp_ref", ramp_ref_freq_o, 600);
    wr(1, 4000);
    chk("jog_freq", freq_command_o, 4000);
    wr(2, 36001);
    wr(2, 36000);
    chk("jog_ramp", ramp_time_o, 36000);
    ramp_pattern_select_i = 1;
    wt;
    chk("ramp_ref", ramp_ref_freq_o, 500);
    {forward_start_i, reverse_start_i} = 2'h1;
    wt;
    chk("rev_run", {run_o, reverse_o}, 3);
    reverse_start_i = 0;
    wt;
    chk("jog_stop", run_o, 0);
    chk("second_ramp", second_ramp_o, 1);
    $display("test jog done");
    {jog_select_i, panel_jog_mode_i, operation_mode_select_i} = 6'h14;
    panel_forward_key_i = 1;
    wt;
    chk("panel_run", run_o, 1);
    {panel_forward_key_i, panel_reverse_key_i} = 2'h1;
    wt;
    chk("panel_rev", {run_o, reverse_o}, 3);
    panel_reverse_key_i = 0;
    wt;
    chk("panel_stop", run_o, 0);
    {operation_mode_select_i, panel_forward_key_i} = 5'h7;
    wt;
    chk("panel_mode3", run_o, 0);
    $display("test panel done");
    report_and_stop;
  end
endmodule
